/* inc/event_counter_pkg.sv */
// Purpose: Shared constants and types for the eight channel event counter
// Assumes: 100 MHz sys_clk
// Notes: Mode and output policy encodings are local to this design
package event_counter_pkg;
  localparam int NUM_CHANNELS = 8;
  localparam int COUNT_WIDTH = 32;
  localparam int GROUP_SIZE = 4;
  localparam int MODE_WIDTH = 3;
  localparam int IRQ_SRC_PER_CHANNEL = 4;
  localparam int DOSE_IRQ_SOURCES = 5;
  localparam int DIAG_SOURCES = 5;
  localparam logic [31:0] LIMIT_MIN = 32'h0000_0002;
  localparam logic [31:0] LIMIT_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
  // Diagnostic vector bit positions
  localparam int DIAG_SUPPLY = 0;
  localparam int DIAG_CONFIG = 1;
  localparam int DIAG_WATCHDOG = 2;
  localparam int DIAG_IRQ_LOST = 3;
  localparam int DIAG_WIRE = 4;
  // Per-channel interrupt source positions
  localparam int IRQ_GATE_RISE = 0;
  localparam int IRQ_GATE_FALL = 1;
  localparam int IRQ_COMPARE = 2;
  localparam int IRQ_END = 3;
  // Dosing group interrupt positions: four compares then end
  localparam int DOSE_IRQ_END = 4;

  typedef enum logic [2:0] {
    MODE_CONTINUOUS = 3'h0,
    MODE_SINGLE = 3'h1,
    MODE_PERIODIC = 3'h2,
    MODE_FREQUENCY = 3'h3,
    MODE_SPEED = 3'h4,
    MODE_PERIOD = 3'h5,
    MODE_DOSING = 3'h6
  } count_mode_type;

  typedef enum logic [1:0] {
    STOP_OUT_HOLD = 2'h0,
    STOP_OUT_SUBST = 2'h1,
    STOP_OUT_OFF = 2'h2
  } stop_out_type;

  typedef enum logic [2:0] {
    CH_IDLE = 3'b001,
    CH_RUN = 3'b010,
    CH_DONE = 3'b100
  } chan_state_type;
endpackage

/* hdl/input_sync.sv */
// Purpose: Two flip-flop synchroniser for a bundle of pin inputs
// Assumes: Inputs asynchronous to sys_clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

/* hdl/event_counter.sv */
// Purpose: Eight channel up/down event counter with compare outputs and interrupts
// Assumes: Field pins asynchronous; control ports synchronous to sys_clk
// Notes: Measurement modes count edges in a gate window; scaling is left to software
// What this block does
// - Eight independent channels, each with counter, gate, direction and output.
// - Each counter is a signed 32-bit two's-complement value.
// - Modes: continuous, single, periodic, frequency, speed, period, dosing.
// - Count runs on software gate alone, or hardware and software gate together.
// - Count limits act only in single, periodic and dosing modes.
// - Main direction up: start at zero, end value between 2 and 2147483647.
// - Main direction down: start value between 2 and 2147483647, end at zero.
// - One compare value per channel, four per dosing group; hit drives output/interrupt.
// - Up to four interrupt sources per channel, two from gate edges.
// - Two mode-specific interrupt sources per channel; five per dosing group.
// - Diagnostic interrupt on supply, config, watchdog, lost interrupt or wire fault.
// - Output comes from compare logic or a software control bit.
// - On controller stop each channel keeps running or halts, as configured.
// - On controller stop outputs hold, take substitutes, or go off.
// - Substitute values also apply to otherwise disabled outputs.
// - Dosing occupies channels 0 to 3 or 4 to 7.
// - Prepared load value is taken when end value is reached counting up, or in either direction when main direction is down.
`timescale 1ns/1ps
module event_counter
  import event_counter_pkg::*;
#(
  parameter int CHANNELS = event_counter_pkg::NUM_CHANNELS,
  parameter int WIDTH = event_counter_pkg::COUNT_WIDTH
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Field inputs
  input wire logic [CHANNELS-1:0] count_pin,
  input wire logic [CHANNELS-1:0] dir_pin,
  input wire logic [CHANNELS-1:0] hw_gate_pin,
  // Channel configuration
  input wire logic config_valid,
  input wire logic [CHANNELS*3-1:0] mode_cfg,
  input wire logic [CHANNELS-1:0] main_down,
  input wire logic [CHANNELS-1:0] invert_dir,
  input wire logic [CHANNELS-1:0] use_hw_gate,
  input wire logic [CHANNELS*WIDTH-1:0] limit_value,
  input wire logic [CHANNELS*WIDTH-1:0] compare_value,
  input wire logic [CHANNELS-1:0] compare_sets_out,
  input wire logic [CHANNELS-1:0] output_enable,
  input wire logic [CHANNELS-1:0] output_sw_ctrl,
  input wire logic [CHANNELS-1:0] output_sw_value,
  input wire logic [CHANNELS*IRQ_SRC_PER_CHANNEL-1:0] irq_enable,
  // Load value control
  input wire logic [CHANNELS*WIDTH-1:0] load_value,
  input wire logic [CHANNELS-1:0] load_direct,
  input wire logic [CHANNELS-1:0] load_prepare,
  // Software gate and controller stop
  input wire logic [CHANNELS-1:0] sw_gate,
  input wire logic cpu_stop,
  input wire logic [CHANNELS-1:0] stop_halts,
  input wire logic [1:0] stop_out_policy,
  input wire logic [CHANNELS-1:0] subst_value,
  // Diagnostic sources
  input wire logic supply_fault,
  input wire logic watchdog_timeout,
  input wire logic [CHANNELS-1:0] wire_fault,
  input wire logic irq_ack,
  // Results
  output logic [CHANNELS*WIDTH-1:0] count_value,
  output logic [CHANNELS-1:0] digital_out,
  output logic [CHANNELS-1:0] gate_open,
  output logic [CHANNELS*IRQ_SRC_PER_CHANNEL-1:0] irq_pending,
  output logic [DOSE_IRQ_SOURCES*2-1:0] dose_irq_pending,
  output logic hw_irq,
  output logic [DIAG_SOURCES-1:0] diag_status,
  output logic diag_irq
);
  logic [CHANNELS-1:0] cnt_s, dir_s, gate_s;
  logic [CHANNELS-1:0] cnt_prev_q, cnt_prev_d, gate_prev_q, gate_prev_d;
  logic [CHANNELS-1:0] out_q, out_d, gate_q, gate_d;
  logic [CHANNELS*WIDTH-1:0] count_q, count_d, pend_load_q, pend_load_d;
  logic [CHANNELS-1:0] pend_valid_q, pend_valid_d;
  logic [CHANNELS*IRQ_SRC_PER_CHANNEL-1:0] irq_q, irq_d;
  logic [DOSE_IRQ_SOURCES*2-1:0] dose_q, dose_d;
  logic [DIAG_SOURCES-1:0] diag_q, diag_d;
  chan_state_type [CHANNELS-1:0] state_q, state_d;

  // Field pins cross into sys_clk here
  input_sync #(.WIDTH(3*CHANNELS)) input_sync_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in({count_pin, dir_pin, hw_gate_pin}),
    .sync_out({cnt_s, dir_s, gate_s})
  );

  function automatic logic limited_mode(input logic [2:0] m);
    limited_mode = (m == MODE_SINGLE) || (m == MODE_PERIODIC) || (m == MODE_DOSING);
  endfunction

  function automatic logic [WIDTH-1:0] clamp_limit(input logic [WIDTH-1:0] v);
    if ($signed(v) < $signed(LIMIT_MIN))
      clamp_limit = LIMIT_MIN;
    else
      clamp_limit = v;
  endfunction

  // Dosing group membership: group 0 = channels 0..3, group 1 = 4..7
  function automatic logic group_dosing(input logic [CHANNELS*3-1:0] mc, input int g);
    group_dosing = (mc[g*GROUP_SIZE*3 +: 3] == MODE_DOSING);
  endfunction

  logic any_irq_new;
  logic [CHANNELS-1:0] halted;

  always_comb
  begin
    logic [WIDTH-1:0] cur, lim, start, endv, nxt;
    logic [2:0] m;
    logic edge_q, up, hit_end, hit_cmp, cnt_on, dosing_ch;
    int g;
    cur = '0;
    lim = '0;
    start = '0;
    endv = '0;
    nxt = '0;
    m = '0;
    edge_q = 1'b0;
    up = 1'b0;
    hit_end = 1'b0;
    hit_cmp = 1'b0;
    cnt_on = 1'b0;
    dosing_ch = 1'b0;
    g = 0;
    count_d = count_q;
    pend_load_d = pend_load_q;
    pend_valid_d = pend_valid_q;
    out_d = out_q;
    gate_d = gate_q;
    state_d = state_q;
    cnt_prev_d = clk_en ? cnt_s : cnt_prev_q;
    gate_prev_d = clk_en ? gate_s : gate_prev_q;
    irq_d = irq_q;
    dose_d = dose_q;
    any_irq_new = 1'b0;
    halted = '0;
    if (irq_ack)
    begin
      irq_d = '0;
      dose_d = '0;
    end
    for (int c = 0; c < CHANNELS; c++)
    begin
      g = c / GROUP_SIZE;
      dosing_ch = group_dosing(mode_cfg, g);
      m = dosing_ch ? MODE_DOSING : mode_cfg[c*3 +: 3];
      cur = count_q[c*WIDTH +: WIDTH];
      lim = clamp_limit(limit_value[c*WIDTH +: WIDTH]);
      start = main_down[c] ? lim : COUNT_ZERO;
      endv = main_down[c] ? COUNT_ZERO : lim;
      halted[c] = cpu_stop && stop_halts[c];
      // Gate: software alone or hardware AND software
      gate_d[c] = config_valid && !halted[c] && sw_gate[c] && (!use_hw_gate[c] || gate_s[c]);
      if (load_prepare[c])
      begin
        pend_load_d[c*WIDTH +: WIDTH] = load_value[c*WIDTH +: WIDTH];
        pend_valid_d[c] = 1'b1;
      end
      if (gate_s[c] && !gate_prev_q[c] && irq_enable[c*4+IRQ_GATE_RISE])
        irq_d[c*4+IRQ_GATE_RISE] = 1'b1;
      if (!gate_s[c] && gate_prev_q[c] && irq_enable[c*4+IRQ_GATE_FALL])
        irq_d[c*4+IRQ_GATE_FALL] = 1'b1;
      edge_q = cnt_s[c] && !cnt_prev_q[c];
      up = dir_s[c] ^ invert_dir[c];
      cnt_on = gate_q[c] && edge_q;
      nxt = up ? cur + 32'h0000_0001 : cur - 32'h0000_0001;
      hit_end = limited_mode(m) && (nxt == endv);
      // Only a running channel moves its count, so only it can hit
      hit_cmp = cnt_on && (state_q[c] == CH_RUN) && (nxt == compare_value[c*WIDTH +: WIDTH]);
      case (state_q[c])
        CH_IDLE:
        begin
          if (gate_q[c])
          begin
            state_d[c] = CH_RUN;
            if (limited_mode(m))
              count_d[c*WIDTH +: WIDTH] = start;
          end
        end
        CH_RUN:
        begin
          if (!gate_q[c])
            state_d[c] = CH_IDLE;
          else if (cnt_on)
          begin
            count_d[c*WIDTH +: WIDTH] = nxt;
            if (hit_end)
            begin
              if (irq_enable[c*4+IRQ_END])
                irq_d[c*4+IRQ_END] = 1'b1;
              if (dosing_ch)
                dose_d[g*DOSE_IRQ_SOURCES+DOSE_IRQ_END] = 1'b1;
              if (pend_valid_q[c] && (up || main_down[c]))
              begin
                count_d[c*WIDTH +: WIDTH] = pend_load_q[c*WIDTH +: WIDTH];
                // A value prepared in this very cycle stays pending
                pend_valid_d[c] = load_prepare[c];
              end
              else if (m == MODE_PERIODIC)
                count_d[c*WIDTH +: WIDTH] = start;
              else
                state_d[c] = CH_DONE;
            end
          end
        end
        CH_DONE:
        begin
          if (!gate_q[c])
            state_d[c] = CH_IDLE;
        end
        default: state_d[c] = CH_IDLE;
      endcase
      if (hit_cmp)
      begin
        out_d[c] = compare_sets_out[c];
        if (irq_enable[c*4+IRQ_COMPARE])
          irq_d[c*4+IRQ_COMPARE] = 1'b1;
        if (dosing_ch)
          dose_d[g*DOSE_IRQ_SOURCES + c%GROUP_SIZE] = 1'b1;
      end
      if (load_direct[c])
        count_d[c*WIDTH +: WIDTH] = load_value[c*WIDTH +: WIDTH];
      if (!config_valid)
        state_d[c] = CH_IDLE;
    end
    any_irq_new = |(irq_d & ~irq_q);
    if (!clk_en)
    begin
      count_d = count_q;
      pend_load_d = pend_load_q;
      pend_valid_d = pend_valid_q;
      out_d = out_q;
      gate_d = gate_q;
      state_d = state_q;
      irq_d = irq_q;
      dose_d = dose_q;
      any_irq_new = 1'b0;
    end
  end

  // Diagnostic flags: set beats acknowledge
  always_comb
  begin
    logic [DIAG_SOURCES-1:0] ev;
    ev = '0;
    ev[DIAG_SUPPLY] = supply_fault;
    ev[DIAG_CONFIG] = !config_valid;
    ev[DIAG_WATCHDOG] = watchdog_timeout;
    ev[DIAG_IRQ_LOST] = any_irq_new && hw_irq && !irq_ack;
    ev[DIAG_WIRE] = |wire_fault;
    diag_d = diag_q;
    if (clk_en)
      diag_d = (irq_ack ? '0 : diag_q) | ev;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= '0;
      pend_load_q <= '0;
      pend_valid_q <= '0;
      out_q <= '0;
      gate_q <= '0;
      state_q <= {CHANNELS{CH_IDLE}};
      cnt_prev_q <= '0;
      gate_prev_q <= '0;
      irq_q <= '0;
      dose_q <= '0;
      diag_q <= '0;
    end
    else
    begin
      count_q <= count_d;
      pend_load_q <= pend_load_d;
      pend_valid_q <= pend_valid_d;
      out_q <= out_d;
      gate_q <= gate_d;
      state_q <= state_d;
      cnt_prev_q <= cnt_prev_d;
      gate_prev_q <= gate_prev_d;
      irq_q <= irq_d;
      dose_q <= dose_d;
      diag_q <= diag_d;
    end
  end

  // Output select; substitutes override the enable on purpose
  logic [CHANNELS-1:0] pin_q, pin_d;
  always_comb
  begin
    pin_d = pin_q;
    for (int c = 0; c < CHANNELS; c++)
    begin
      if (!cpu_stop)
        pin_d[c] = output_enable[c] && (output_sw_ctrl[c] ? output_sw_value[c] : out_q[c]);
      else if (stop_out_policy == STOP_OUT_SUBST)
        pin_d[c] = subst_value[c];
      else if (stop_out_policy == STOP_OUT_OFF)
        pin_d[c] = 1'b0;
    end
    if (!config_valid || !clk_en)
      pin_d = config_valid ? pin_q : '0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pin_q <= '0;
    else
      pin_q <= pin_d;
  end

  assign count_value = count_q;
  assign digital_out = pin_q;
  assign gate_open = gate_q;
  assign irq_pending = irq_q;
  assign dose_irq_pending = dose_q;
  assign hw_irq = |irq_q || |dose_q;
  assign diag_status = diag_q;
  assign diag_irq = |diag_q;
endmodule

/* testbench/event_counter_sva.sv */
// Purpose: Port-level checks for the event counter
// Assumes: Default parameters, one clock domain
// Notes: Output checks need three steady cycles for the extra output stage
`timescale 1ns/1ps
module event_counter_sva
  import event_counter_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Controls
  input wire logic config_valid,
  input wire logic [23:0] mode_cfg,
  input wire logic [7:0] load_direct,
  input wire logic [7:0] sw_gate,
  input wire logic [7:0] output_enable,
  input wire logic [7:0] output_sw_ctrl,
  input wire logic [7:0] output_sw_value,
  input wire logic cpu_stop,
  input wire logic [1:0] stop_out_policy,
  input wire logic [7:0] subst_value,
  input wire logic irq_ack,
  // Results
  input wire logic [255:0] count_value,
  input wire logic [7:0] digital_out,
  input wire logic [7:0] gate_open,
  input wire logic [31:0] irq_pending,
  input wire logic [9:0] dose_irq_pending,
  input wire logic hw_irq,
  input wire logic [4:0] diag_status,
  input wire logic diag_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  property p_reset_clear;
    $fell(rst) |-> count_value == '0 && digital_out == '0 && irq_pending == '0 && gate_open == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("state not clear after reset");
  property p_hw_irq;
    clk_en && !irq_ack && |irq_pending
      |=> hw_irq && (irq_pending & $past(irq_pending)) == $past(irq_pending);
  endproperty
  a_hw_irq: assert property (p_hw_irq) else $error("hw_irq differs from pending");
  property p_diag_irq;
    clk_en && !irq_ack && |diag_status
      |=> diag_irq && (diag_status & $past(diag_status)) == $past(diag_status);
  endproperty
  a_diag_irq: assert property (p_diag_irq) else $error("diag_irq differs from status");
  property p_config_diag;
    clk_en && !config_valid |=> diag_status[DIAG_CONFIG];
  endproperty
  a_config_diag: assert property (p_config_diag) else $error("config fault not flagged");
  property p_gate_sw;
    clk_en && config_valid && sw_gate == '0 |=> gate_open == '0;
  endproperty
  a_gate_sw: assert property (p_gate_sw) else $error("gate open without sw gate");
  property p_count_step;
    clk_en && config_valid && mode_cfg[2:0] == MODE_CONTINUOUS && !load_direct[0]
      |=> (count_value[31:0] - $past(count_value[31:0])) inside {32'h0, 32'h1, 32'hFFFF_FFFF};
  endproperty
  a_count_step: assert property (p_count_step) else $error("count moved by more than one");
  property p_sw_out;
    (clk_en && config_valid && !cpu_stop && output_enable[0] && output_sw_ctrl[0]
      && $stable(output_sw_value[0]))[*3] |-> digital_out[0] == output_sw_value[0];
  endproperty
  a_sw_out: assert property (p_sw_out) else $error("output ignores sw control");
  property p_subst;
    (clk_en && config_valid && cpu_stop && stop_out_policy == STOP_OUT_SUBST
      && $stable(subst_value))[*3] |-> digital_out == subst_value;
  endproperty
  a_subst: assert property (p_subst) else $error("substitute values not shown");
  property p_stop_off;
    (clk_en && config_valid && cpu_stop && stop_out_policy == STOP_OUT_OFF)[*3] |-> digital_out == '0;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("outputs on while stopped off");
  c_out: cover property (digital_out[0]);
  c_irq: cover property (|irq_pending);
  c_subst: cover property (cpu_stop && stop_out_policy == STOP_OUT_SUBST);
  c_dose: cover property (|dose_irq_pending);
endmodule
bind event_counter event_counter_sva event_counter_sva_i (.*);

/* testbench/field_side.sv */
// Purpose: Encoder and gate pins of the field side
// Assumes: Bounce-free encoder; dir_pin high counts up
// Notes: Six clock pulses so the synchroniser sees every edge
`timescale 1ns/1ps
module field_side (
  // Clock
  input wire logic sys_clk,
  // Pins
  output logic [7:0] count_pin,
  output logic [7:0] dir_pin,
  output logic [7:0] hw_gate_pin
);
  initial
  begin
    {count_pin, dir_pin, hw_gate_pin} = '0;
  end
  task automatic pulses(input int ch, input int n, input logic dn);
    dir_pin[ch] = !dn;
    repeat (n)
    begin
      repeat (3) @(posedge sys_clk);
      #1 count_pin[ch] = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 count_pin[ch] = 1'b0;
    end
  endtask
  task automatic gate(input int ch, input logic lvl);
    @(posedge sys_clk);
    #1 hw_gate_pin[ch] = lvl;
  endtask
endmodule

/* testbench/event_counter_tb.sv */
// Purpose: Self-checking bench for the event counter
// Assumes: dir_pin high counts up
// Notes: Driver queues expectations, a monitor compares them
`timescale 1ns/1ps
module event_counter_tb;
  import event_counter_pkg::*;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
  typedef struct {int kind; int idx; logic [31:0] exp;} note_type;
  note_type notes[$];
  string kinds[5] = '{"count", "outputs", "irq", "diag", "dose"};
  event look;
  int n_errors = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'hC2DE4ED4;
  logic [31:0] v;
  logic sys_clk, rst, clk_en, config_valid, cpu_stop, supply_fault, watchdog_timeout, irq_ack;
  logic hw_irq, diag_irq;
  logic [7:0] count_pin, dir_pin, hw_gate_pin, main_down, invert_dir, use_hw_gate, gate_open;
  logic [7:0] compare_sets_out, output_enable, output_sw_ctrl, output_sw_value, digital_out;
  logic [7:0] load_direct, load_prepare, sw_gate, stop_halts, subst_value, wire_fault;
  logic [23:0] mode_cfg;
  logic [255:0] limit_value, compare_value, load_value, count_value;
  logic [31:0] irq_enable, irq_pending;
  logic [1:0] stop_out_policy;
  logic [9:0] dose_irq_pending;
  logic [4:0] diag_status;
  event_counter event_counter_i (.*);
  field_side field_side_i (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic expect_val(input int kind, input int idx, input logic [31:0] e);
    notes.push_back('{kind, idx, e});
  endtask
  task automatic settle();
    step(4);
    -> look;
    step(1);
  endtask
  task automatic ack();
    irq_ack = 1'b1;
    step(1);
    irq_ack = 1'b0;
    step(1);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(look)
  begin
    note_type n;
    logic [31:0] got;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.kind)
        0: got = count_value[n.idx*32 +: 32];
        1: got = {24'h0, digital_out};
        2: got = irq_pending;
        4: got = {21'h0, hw_irq, dose_irq_pending};
        default: got = {26'h0, diag_irq, diag_status};
      endcase
      `CHK(kinds[n.kind], n.exp, got)
    end
  end
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #300000;
    n_errors++;
    close_out();
  end
  initial
  begin
    {rst, clk_en, config_valid, cpu_stop, supply_fault, watchdog_timeout, irq_ack} = 7'h60;
    {main_down, invert_dir, use_hw_gate, compare_sets_out, output_enable, output_sw_ctrl} = '0;
    {output_sw_value, load_direct, load_prepare, sw_gate, stop_halts, subst_value} = '0;
    {wire_fault, mode_cfg, limit_value, compare_value, load_value, stop_out_policy} = '0;
    irq_enable = '1;
    step(6);
    rst = 1'b0;
    step(2);
    expect_val(3, 0, 32'h22);
    expect_val(0, 0, 32'h0);
    expect_val(2, 0, 32'h0);
    settle();
    config_valid = 1'b1;
    ack();
    for (int i = 0; i < 3; i++)
    begin
      {wire_fault[0], watchdog_timeout, supply_fault} = 3'b001 << i;
      step(2);
      {wire_fault[0], watchdog_timeout, supply_fault} = 3'b000;
      expect_val(3, 0, 32'h20 | (32'h1 << (2 * i)));
      settle();
      ack();
    end
    sw_gate[0] = 1'b1;
    field_side_i.pulses(0, 7, 1'b0);
    expect_val(0, 0, 32'h7);
    settle();
    field_side_i.pulses(0, 7, 1'b1);
    expect_val(0, 0, 32'h0);
    settle();
    invert_dir[0] = 1'b1;
    field_side_i.pulses(0, 3, 1'b1);
    expect_val(0, 0, 32'h3);
    settle();
    invert_dir[0] = 1'b0;
    sw_gate[0] = 1'b0;
    field_side_i.pulses(0, 2, 1'b0);
    expect_val(0, 0, 32'h3);
    settle();
    {use_hw_gate[0], sw_gate[0], compare_sets_out[0], output_enable[0]} = 4'hF;
    compare_value[31:0] = 32'h4;
    field_side_i.pulses(0, 2, 1'b0);
    expect_val(0, 0, 32'h3);
    settle();
    ack();
    field_side_i.gate(0, 1'b1);
    field_side_i.pulses(0, 1, 1'b0);
    expect_val(0, 0, 32'h4);
    expect_val(1, 0, 32'h1);
    expect_val(2, 0, 32'h5);
    settle();
    ack();
    field_side_i.gate(0, 1'b0);
    expect_val(2, 0, 32'h2);
    output_sw_ctrl[0] = 1'b1;
    expect_val(1, 0, 32'h0);
    settle();
    output_sw_value[0] = 1'b1;
    expect_val(1, 0, 32'h1);
    settle();
    v = rnd();
    {output_enable, subst_value, stop_out_policy} = {8'h00, v[7:0], STOP_OUT_SUBST};
    {cpu_stop, stop_halts[0], use_hw_gate[0]} = 3'b110;
    field_side_i.pulses(0, 2, 1'b0);
    expect_val(0, 0, 32'h4);
    expect_val(1, 0, {24'h0, subst_value});
    settle();
    stop_out_policy = STOP_OUT_HOLD;
    subst_value = ~v[7:0];
    expect_val(1, 0, {24'h0, v[7:0]});
    settle();
    stop_out_policy = STOP_OUT_OFF;
    expect_val(1, 0, 32'h0);
    settle();
    cpu_stop = 1'b0;
    foreach (kinds[i])
    begin
      v = (i == 0) ? 32'h8000_0000 : (i == 1) ? 32'h7FFF_FFFF : rnd();
      load_value[31:0] = v;
      load_direct[0] = 1'b1;
      step(1);
      load_direct[0] = 1'b0;
      expect_val(0, 0, v);
      settle();
    end
    // Frozen clock enable must swallow these pulses
    clk_en = 1'b0;
    field_side_i.pulses(0, 2, 1'b0);
    clk_en = 1'b1;
    expect_val(0, 0, v);
    settle();
    mode_cfg[11:3] = {MODE_PERIODIC, MODE_SINGLE, MODE_SINGLE};
    limit_value[127:32] = {32'h3, 32'h5, 32'h1};
    main_down[2] = 1'b1;
    sw_gate[3:1] = 3'h7;
    cpu_stop = 1'b1;
    step(3);
    load_value[127:96] = rnd();
    load_prepare[3] = 1'b1;
    step(1);
    load_prepare[3] = 1'b0;
    field_side_i.pulses(1, 4, 1'b0);
    field_side_i.pulses(2, 7, 1'b1);
    field_side_i.pulses(3, 3, 1'b0);
    expect_val(0, 1, 32'h2);
    expect_val(0, 2, 32'h0);
    expect_val(0, 3, load_value[127:96]);
    settle();
    cpu_stop = 1'b0;
    ack();
    mode_cfg[14:12] = MODE_DOSING;
    limit_value[159:128] = 32'h3;
    compare_value[159:128] = 32'h2;
    sw_gate[4] = 1'b1;
    step(3);
    field_side_i.pulses(4, 3, 1'b0);
    expect_val(0, 4, 32'h3);
    expect_val(2, 0, 32'h000C_0000);
    expect_val(4, 0, 32'h0000_0620);
    settle();
    close_out();
  end
endmodule
